// *** design/sbpa_pkg.sv ***
// Constants and carrier types for the shared bus requesting master
// Operation
// - Only one master; slave addressed singly
// - Every master strobe awaits slave response
// - Fifty-six shared lines, one signal format
// - Data lines driven both ways
// - Direct request first, then levels seven-four
// - Nearer device wins on shared line
// - Arbitration lines separate, overlapped with transfers
// - Direct-gained mastership never interrupts
// - One word per 400 ns best
// - Peripheral registers memory-like, bit 15 error
package sbpa_pkg;
  // Line counts
  localparam int BUS_LINES = 56;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int NUM_LINES = 5;
  // Request line indices, highest priority first
  localparam logic [2:0] LINE_DIRECT = 3'h0;
  localparam logic [2:0] LINE_LEVEL7 = 3'h1;
  localparam logic [2:0] LINE_LEVEL4 = 3'h4;
  // Conventional error flag position in peripheral words
  localparam int ERR_BIT = 15;
  // Timing
  localparam int CLK_NS = 20;
  localparam int WORD_NS = 400;
  localparam int WORD_CYC = (WORD_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_NS = 150;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 5;
  // Synchronised pin vector layout
  localparam int SYNC_W = NUM_LINES + 2 + DATA_W;
  localparam int SYNC_SSYN = NUM_LINES;
  localparam int SYNC_BUSY = NUM_LINES + 1;
  localparam int SYNC_DATA = NUM_LINES + 2;

  typedef enum logic [1:0] {
    SBPA_READ,
    SBPA_WRITE,
    SBPA_INTR
  } sbpa_kind_e;

  typedef struct packed {
    sbpa_kind_e kind;
    logic [2:0] line;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic hold;
  } sbpa_cmd_s;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic devError;
    logic refused;
  } sbpa_resp_s;
endpackage

// *** design/sbpa_bus_master.sv ***
// Requesting master: arbitration, interlocked transfer and interrupt
`timescale 1ns/100ps
module sbpa_bus_master (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  // User side
  input wire logic cmdValid,
  output logic cmdReady,
  input wire sbpa_pkg::sbpa_cmd_s cmd,
  output logic respValid,
  output sbpa_pkg::sbpa_resp_s resp,
  // Arbitration pins
  output logic [sbpa_pkg::NUM_LINES-1:0] reqOut,
  input wire logic [sbpa_pkg::NUM_LINES-1:0] grantIn,
  output logic [sbpa_pkg::NUM_LINES-1:0] grantOut,
  output logic selAckOut,
  // Transfer pins
  input wire logic busyIn,
  output logic busyOut,
  output logic busyOe,
  output logic masterSyncOut,
  output logic masterSyncOe,
  input wire logic slaveSyncIn,
  output logic [sbpa_pkg::ADDR_W-1:0] addrOut,
  output logic addrOe,
  output logic writeOut,
  output logic writeOe,
  input wire logic [sbpa_pkg::DATA_W-1:0] dataIn,
  output logic [sbpa_pkg::DATA_W-1:0] dataOut,
  output logic dataOe,
  output logic intrOut,
  output logic intrOe
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_REQ,
    ST_WAITBUS,
    ST_SETUP,
    ST_STROBE,
    ST_UNSTROBE,
    ST_HOLD
  } sbpa_state_e;

  sbpa_state_e state_r;
  sbpa_state_e state_nxt;
  sbpa_pkg::sbpa_cmd_s cmd_r;
  logic [sbpa_pkg::CNT_W-1:0] setupCnt_r;
  logic [sbpa_pkg::CNT_W-1:0] paceCnt_r;
  logic [sbpa_pkg::SYNC_W-1:0] syncA_r;
  logic [sbpa_pkg::SYNC_W-1:0] syncB_r;
  logic [sbpa_pkg::SYNC_W-1:0] syncC_r;
  logic [sbpa_pkg::SYNC_W-1:0] pinStable_r;
  logic [sbpa_pkg::SYNC_W-1:0] pinRaw;
  logic [sbpa_pkg::NUM_LINES-1:0] reqLine;
  logic [sbpa_pkg::NUM_LINES-1:0] ownLine;
  logic [sbpa_pkg::NUM_LINES-1:0] grantSeen;
  logic ownLineGrant;
  logic slaveSync;
  logic busyOther;
  logic refuseCmd;
  logic takeCmd;
  logic isIntr;
  logic paceDone;
  logic setupDone;
  logic holdNext;
  logic absorbGrant;

  // Raw pin vector in synchroniser order: grants, slave sync, busy, data
  assign pinRaw = {dataIn, busyIn, slaveSyncIn, grantIn};

  // Three-stage pin synchronisers, change accepted when stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < sbpa_pkg::SYNC_W; gi++) begin : g_sync
      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          syncA_r[gi] <= 1'b0;
          syncB_r[gi] <= 1'b0;
          syncC_r[gi] <= 1'b0;
          pinStable_r[gi] <= 1'b0;
        end else if (ce) begin
          syncA_r[gi] <= pinRaw[gi];
          syncB_r[gi] <= syncA_r[gi];
          syncC_r[gi] <= syncB_r[gi];
          if (syncB_r[gi] == syncC_r[gi]) begin
            pinStable_r[gi] <= syncC_r[gi];
          end
        end
      end
    end
  endgenerate

  // Decoded pin and command conditions
  assign grantSeen = pinStable_r[sbpa_pkg::NUM_LINES-1:0];
  assign slaveSync = pinStable_r[sbpa_pkg::SYNC_SSYN];
  assign busyOther = pinStable_r[sbpa_pkg::SYNC_BUSY];
  assign isIntr = (cmd_r.kind == sbpa_pkg::SBPA_INTR);
  assign ownLine = (sbpa_pkg::NUM_LINES)'(1) << cmd_r.line;
  assign reqLine = (state_r == ST_REQ) ? ownLine : '0;
  assign ownLineGrant = |(grantSeen & ownLine);
  // Interrupt only through an interrupt level; direct-line interrupts refused
  assign refuseCmd = (cmd.kind == sbpa_pkg::SBPA_INTR && cmd.line == sbpa_pkg::LINE_DIRECT) ||
                     (cmd.line > sbpa_pkg::LINE_LEVEL4) ||
                     (cmd.kind == sbpa_pkg::SBPA_INTR && cmd.hold);
  assign cmdReady = (state_r == ST_IDLE);
  assign takeCmd = cmdValid && cmdReady;
  assign paceDone = (paceCnt_r >= (sbpa_pkg::CNT_W)'(sbpa_pkg::WORD_CYC));
  assign setupDone = (setupCnt_r >= (sbpa_pkg::CNT_W)'(sbpa_pkg::SETUP_CYC));
  // A follow-on command of a held sequence may start without releasing
  assign holdNext = cmdValid && !refuseCmd && cmd.kind != sbpa_pkg::SBPA_INTR;

  // Daisy chain: our own line's grant is absorbed from request until it drops
  assign absorbGrant = (state_r == ST_REQ) || (state_r == ST_WAITBUS);
  // Any other grant passes on, so nearer devices win
  assign grantOut = absorbGrant ? (grantSeen & ~ownLine) : grantSeen;
  assign reqOut = reqLine;
  assign selAckOut = (state_r == ST_WAITBUS);

  // Pin drive: mastership shown on busy, addressing one slave at a time
  assign busyOe = (state_r == ST_SETUP) || (state_r == ST_STROBE) || (state_r == ST_UNSTROBE)
                  || (state_r == ST_HOLD);
  assign busyOut = busyOe;
  assign addrOe = busyOe && !isIntr;
  assign addrOut = cmd_r.addr;
  assign writeOe = addrOe;
  assign writeOut = (cmd_r.kind == sbpa_pkg::SBPA_WRITE);
  assign dataOe = busyOe && (cmd_r.kind != sbpa_pkg::SBPA_READ);
  assign dataOut = cmd_r.data;
  assign masterSyncOe = (state_r == ST_STROBE) && !isIntr;
  assign masterSyncOut = masterSyncOe;
  assign intrOe = (state_r == ST_STROBE) && isIntr;
  assign intrOut = intrOe;

  // Next-state logic
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (takeCmd && !refuseCmd) begin
          state_nxt = ST_REQ;
        end
      end
      ST_REQ: begin
        if (ownLineGrant) begin
          state_nxt = ST_WAITBUS;
        end
      end
      ST_WAITBUS: begin
        // Own grant gone and lines free before we drive anything
        if (!busyOther && !slaveSync && !ownLineGrant) begin
          state_nxt = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (setupDone) begin
          state_nxt = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (slaveSync) begin
          state_nxt = ST_UNSTROBE;
        end
      end
      ST_UNSTROBE: begin
        if (!slaveSync && paceDone) begin
          state_nxt = cmd_r.hold ? ST_HOLD : ST_IDLE;
        end
      end
      ST_HOLD: begin
        // Only a read or write may follow a held cycle
        if (holdNext) begin
          state_nxt = ST_SETUP;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // State, command capture and counters
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      cmd_r <= '0;
      setupCnt_r <= '0;
      paceCnt_r <= '0;
    end else if (ce) begin
      state_r <= state_nxt;
      if (takeCmd || (state_r == ST_HOLD && holdNext)) begin
        cmd_r <= cmd;
      end
      // Pace counts from bus taken, so each word fills its slot
      setupCnt_r <= (state_r == ST_SETUP) ? setupCnt_r + 1'b1 : '0;
      if (state_r == ST_WAITBUS || state_r == ST_HOLD) begin
        paceCnt_r <= '0;
      end else if (!paceDone) begin
        paceCnt_r <= paceCnt_r + 1'b1;
      end
    end
  end

  // Answer: refusal, read data and error flag
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      respValid <= 1'b0;
      resp <= '0;
    end else if (ce) begin
      respValid <= 1'b0;
      // Refusals answer at once without moving any pin
      if (takeCmd && refuseCmd) begin
        respValid <= 1'b1;
        resp <= '{data: '0, devError: 1'b0, refused: 1'b1};
      end else if (state_r == ST_STROBE && slaveSync) begin
        respValid <= 1'b1;
        resp.refused <= 1'b0;
        resp.data <= (cmd_r.kind == sbpa_pkg::SBPA_READ) ?
                     pinStable_r[sbpa_pkg::SYNC_DATA +: sbpa_pkg::DATA_W] : '0;
        resp.devError <= (cmd_r.kind == sbpa_pkg::SBPA_READ) &&
                         pinStable_r[sbpa_pkg::SYNC_DATA + sbpa_pkg::ERR_BIT];
      end
    end
  end
endmodule

// *** sim/sbpa_properties.sv ***
// Port checker for the requesting master
`timescale 1ns/100ps
module sbpa_properties (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic cmdValid,
  input wire logic cmdReady,
  input wire sbpa_pkg::sbpa_cmd_s cmd,
  input wire logic respValid,
  input wire sbpa_pkg::sbpa_resp_s resp,
  input wire logic [4:0] reqOut,
  input wire logic [4:0] grantOut,
  input wire logic selAckOut,
  input wire logic busyOut,
  input wire logic masterSyncOut,
  input wire logic slaveSyncIn,
  input wire logic addrOe,
  input wire logic dataOe,
  input wire logic intrOut
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Port relations of arbitration and transfer
  chk_one_request: assert property ($onehot0(reqOut)) else $error("two request lines");
  chk_strobe_held: assert property (masterSyncOut && !slaveSyncIn |=> masterSyncOut) else $error("strobe dropped");
  chk_strobe_owner: assert property (masterSyncOut |-> busyOut && addrOe) else $error("strobe not master");
  chk_direct_intr: assert property (cmdValid && cmdReady && cmd.kind == sbpa_pkg::SBPA_INTR && cmd.line == 3'h0
    |=> respValid && resp.refused) else $error("direct interrupt taken");
  chk_word_span: assert property ($fell(busyOut) |-> $past(busyOut, 20)) else $error("bus held too short");
  chk_error_flag: assert property (respValid && !resp.refused |-> resp.devError == resp.data[15])
    else $error("error flag wrong");
  chk_ack_wait: assert property (selAckOut |-> !busyOut) else $error("bus taken early");
  chk_grant_absorbed: assert property (selAckOut |-> grantOut == 5'h0) else $error("own grant passed on");
  chk_intr_vector: assert property (intrOut |-> dataOe && !masterSyncOut) else $error("vector missing");
endmodule
bind sbpa_bus_master sbpa_properties sbpa_properties_i (.*);

// *** sim/sbpa_device_model.sv ***
// Processor and slave memory facing the requesting master
`timescale 1ns/100ps
module sbpa_device_model (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [2:0] prio,
  input wire logic [4:0] dly,
  input wire logic [4:0] reqOut,
  output logic [4:0] grantIn,
  input wire logic masterSyncOut,
  input wire logic intrOut,
  input wire logic writeOut,
  input wire logic [17:0] addrOut,
  input wire logic dataOe,
  input wire logic [15:0] dataOut,
  output logic slaveSyncIn,
  output logic [15:0] dataIn
);
  logic [15:0] mem [16];
  logic [15:0] lastData;
  logic [4:0] waitCnt, ok, pick;
  logic strobe;
  // Direct line always; line n is level 8-n, granted above priority only
  assign ok = reqOut & {prio < 3'h4, prio < 3'h5, prio < 3'h6, prio < 3'h7, 1'b1};
  assign pick = ok & -ok;
  assign strobe = masterSyncOut | intrOut;
  // Master word while it drives data, slave word while answering, else a toggling pattern
  assign dataIn = dataOe ? dataOut : (strobe | slaveSyncIn) ? mem[addrOut[4:1]] : ~lastData;
  // Grants between cycles; acknowledge after dly
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      grantIn <= 5'h0;
      waitCnt <= 5'h0;
      slaveSyncIn <= 1'b0;
      lastData <= 16'h0;
    end else begin
      grantIn <= strobe ? grantIn & reqOut : pick;
      waitCnt <= strobe ? waitCnt + 5'h1 : 5'h0;
      slaveSyncIn <= strobe && waitCnt >= dly;
      lastData <= dataIn;
      if (strobe && writeOut && waitCnt == dly) begin
        mem[addrOut[4:1]] <= dataOut;
      end
    end
  end
endmodule

// *** sim/testbench.sv ***
// Self-checking bench for the requesting master
`timescale 1ns/100ps
module testbench;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic cmdValid = 1'b0;
  logic ce = 1'b1;
  logic holdReq = 1'b0;
  logic [15:0] vector;
  logic [2:0] prio = 3'h0;
  logic [4:0] dly = 5'h0;
  sbpa_pkg::sbpa_cmd_s cmd = '0;
  sbpa_pkg::sbpa_resp_s resp;
  logic cmdReady, respValid, busyOut, busyOe, masterSyncOut, slaveSyncIn, writeOut, dataOe, intrOut;
  logic [4:0] reqOut, grantIn;
  logic [17:0] addrOut;
  logic [15:0] dataOut, dataIn;
  int n_fail = 0;
  int checks = 0;
  int mem [int];
  always #10 mclk = ~mclk;
  // Interrupt vector as the processor side latches it
  always @(posedge mclk) begin
    if (intrOut === 1'b1) vector <= dataOut;
  end
  // Master is the only party on the busy line
  sbpa_bus_master sbpa_bus_master_i (.*, .ce(ce), .busyIn(busyOut & busyOe), .grantOut(), .selAckOut(),
    .masterSyncOe(), .addrOe(), .writeOe(), .intrOe());
  sbpa_device_model sbpa_device_model_i (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wt(input int lim, output logic got);
    got = 1'b0;
    for (int i = 0; i < lim && !got; i++) begin
      if (respValid === 1'b1) got = 1'b1;
      else @(negedge mclk);
    end
  endtask
  task automatic op(input sbpa_pkg::sbpa_kind_e k, input logic [2:0] ln, input logic [17:0] a,
    input logic [15:0] d, input int lim, output logic got);
    @(negedge mclk);
    while (!cmdReady) @(negedge mclk);
    cmd = '{k, ln, a, d, holdReq};
    cmdValid = 1'b1;
    @(negedge mclk);
    cmdValid = 1'b0;
    wt(lim, got);
  endtask
  // Main sequence
  initial begin
    logic got;
    logic rel;
    logic [17:0] a;
    logic [15:0] d;
    void'($urandom(32'hB79A08A0));
    repeat (10) @(negedge mclk);
    rst_b = 1'b1;
    // Write and read back on every line with random slave delay
    for (int ln = 0; ln < 5; ln++) begin
      a = {13'h0, 4'($urandom), 1'b0};
      d = 16'($urandom);
      dly = 5'($urandom % 8);
      mem[a] = d;
      op(sbpa_pkg::SBPA_WRITE, 3'(ln), a, d, 400, got);
      chk(got, 1);
      op(sbpa_pkg::SBPA_READ, 3'(ln), a, 16'h0, 400, got);
      chk(resp, {16'(mem[a]), 1'(mem[a] >> 15), 1'b0});
    end
    // Read-modify-write: second word follows with no release or re-arbitration
    holdReq = 1'b1;
    op(sbpa_pkg::SBPA_READ, 3'h0, a, 16'h0, 400, got);
    holdReq = 1'b0;
    chk(resp, {16'(mem[a]), 1'(mem[a] >> 15), 1'b0});
    mem[a] = ~mem[a];
    cmd = '{sbpa_pkg::SBPA_WRITE, 3'h2, a, 16'(mem[a]), 1'b0};
    cmdValid = 1'b1;
    rel = 1'b0;
    for (int i = 0; i < 100 && masterSyncOut !== 1'b1; i++) begin
      @(negedge mclk);
      rel = rel | (reqOut !== 5'h0) | (busyOut !== 1'b1);
    end
    cmdValid = 1'b0;
    wt(400, got);
    chk({got, rel}, 2'b10);
    op(sbpa_pkg::SBPA_READ, 3'h3, a, 16'h0, 400, got);
    chk(resp, {16'(mem[a]), 1'(mem[a] >> 15), 1'b0});
    // Interrupt on direct line and line out of range are refused
    for (int i = 0; i < 2; i++) begin
      op(i ? sbpa_pkg::SBPA_READ : sbpa_pkg::SBPA_INTR, i ? 3'h5 : 3'h0, 18'h0, 16'h0, 10, got);
      chk({got, resp.refused, reqOut}, 7'h60);
    end
    // Each level blocked at equal priority, granted one below
    for (int ln = 1; ln < 5; ln++) begin
      prio = 3'(8 - ln);
      op(sbpa_pkg::SBPA_INTR, 3'(ln), 18'h0, 16'(ln), 60, got);
      chk(got, 0);
      ce = 1'b0;
      prio = 3'(7 - ln);
      repeat (20) @(negedge mclk);
      chk({reqOut, busyOut, grantIn[ln]}, {5'h1 << ln, 2'b01});
      ce = 1'b1;
      wt(400, got);
      chk({got, resp.refused}, 2'b10);
      chk(vector, ln);
    end
    report_and_stop;
  end
  // Watchdog
  initial begin
    #1000000;
    n_fail++;
    report_and_stop;
  end
endmodule
